// ===== adcif_core_model.sv
// converter core stand-in: a code per unit from the input in work
`timescale 1ns/1ps
module adcif_core_model
  import adcif_pkg::*;
(
  input  wire logic [UNITS-1:0][1:0]       chan_sel_i,
  input  wire logic [UNITS-1:0]            busy_i,
  output logic      [UNITS-1:0][RES_W-1:0] core_data_o
);
  // idle core shows the inverse so a stray sample is caught
  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      core_data_o[u] = 10'h2A5 ^ {u[1:0], chan_sel_i[u], 4'h5, chan_sel_i[u]};
      if (!busy_i[u])
        core_data_o[u] = ~core_data_o[u];
    end
  end
endmodule : adcif_core_model

// ===== adcif_pkg.sv
// shared constants and types for the dual converter register block
package adcif_pkg;

  localparam int unsigned UNITS = 2;
  localparam int unsigned CHANS = 4;
  localparam int unsigned RES_W = 10;

  // byte offsets on the 8-bit register port
  localparam logic [4:0] RESULT_BASE = 5'h00;
  localparam logic [4:0] RESULT_LAST = 5'h0F;
  localparam logic [4:0] CSR0_OFF    = 5'h10;
  localparam logic [4:0] CSR1_OFF    = 5'h11;
  localparam logic [4:0] TCR0_OFF    = 5'h12;
  localparam logic [4:0] TCR1_OFF    = 5'h13;
  localparam int unsigned UNIT_SEL_BIT = 3;

  // control/status field positions
  localparam int unsigned FLAG_BIT  = 7;
  localparam int unsigned IE_BIT    = 6;
  localparam int unsigned RUN_BIT   = 5;
  localparam int unsigned SCAN_BIT  = 4;
  localparam int unsigned SPEED_BIT = 3;
  localparam int unsigned TRIGGER_ENABLE_BIT_BIT  = 7;

  localparam logic [7:0] CSR_RESET     = 8'h00;
  localparam logic [6:0] TCR_RSVD_ONES = 7'h7F;
  localparam logic [7:0] RDATA_NONE    = 8'h00;
  localparam logic [5:0] LOW_PAD       = 6'h00;

  // conversion times in states; one state is one clock
  localparam int unsigned FIRST_SLOW_STATES = 266;
  localparam int unsigned FIRST_FAST_STATES = 134;
  localparam int unsigned NEXT_SLOW_STATES  = 256;
  localparam int unsigned NEXT_FAST_STATES  = 128;
  localparam int unsigned CYCLES_PER_STATE  = 1;
  localparam logic [8:0] FIRST_SLOW_CYC =
    9'(FIRST_SLOW_STATES * CYCLES_PER_STATE);
  localparam logic [8:0] FIRST_FAST_CYC =
    9'(FIRST_FAST_STATES * CYCLES_PER_STATE);
  localparam logic [8:0] NEXT_SLOW_CYC =
    9'(NEXT_SLOW_STATES * CYCLES_PER_STATE);
  localparam logic [8:0] NEXT_FAST_CYC =
    9'(NEXT_FAST_STATES * CYCLES_PER_STATE);
  localparam logic [8:0] CNT_ONE  = 9'h001;
  localparam logic [8:0] CNT_ZERO = 9'h000;

  typedef struct packed {
    logic [4:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } adcif_bus_req_t;

  typedef struct packed {
    logic [CHANS-1:0][RES_W-1:0] result;
    logic       end_flag;
    logic       interrupt_enable_bit;
    logic       run;
    logic       scan;
    logic       speed_bit;
    logic [1:0] channel_field;
    logic       trigger_enable_bit;
    logic       flag_seen;
    logic [1:0] cur;
    logic [8:0] cnt;
  } adcif_unit_t;

  typedef struct packed {
    adcif_unit_t [UNITS-1:0] u;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic       pin_prev;
  } adcif_state_t;

endpackage : adcif_pkg

// ===== adcif_tb.sv
// self-checking bench for the dual converter register block
`timescale 1ns/1ps
module testbench;
  import adcif_pkg::*;
  logic                        ref_clk_i = 1'b0;
  logic                        reset_i = 1'b1;
  logic                        standby = 1'b0;
  adcif_bus_req_t              req = '0;
  logic [7:0]                  rdata;
  logic                        pin_n = 1'b1;
  logic                        timer = 1'b0;
  logic [UNITS-1:0]            xfer = '0;
  logic [UNITS-1:0][RES_W-1:0] core;
  logic [UNITS-1:0][1:0]       sel;
  logic [UNITS-1:0]            conv;
  logic [UNITS-1:0]            irq;
  logic [7:0]                  rd;
  int                          num_errors = 0;
  int                          check_count = 0;
  int                          n;

  always #12.5 ref_clk_i = ~ref_clk_i;

  adcif_top i_adcif_top (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .standby_i(standby),
    .bus_req_i(req), .bus_rdata_o(rdata),
    .external_trigger_pin_n_i(pin_n), .timer_trigger_i(timer),
    .xfer_access_i(xfer), .core_data_i(core), .channel_sel_o(sel),
    .converting_o(conv), .completion_interrupt_o(irq));

  adcif_core_model i_adcif_core_model (
    .chan_sel_i(sel), .busy_i(conv), .core_data_o(core));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic bus_rd(input logic [4:0] a);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge ref_clk_i);
    rd = rdata;
    req.rd = 1'b0;
    @(negedge ref_clk_i);
  endtask : bus_rd

  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge ref_clk_i);
    req.wr = 1'b0;
    @(negedge ref_clk_i);
  endtask : bus_wr

  function automatic logic [9:0] code(input logic [1:0] u, c);
    return 10'h2A5 ^ {u, c, 4'h5, c};
  endfunction : code

  task automatic res_chk(input logic [1:0] u, c);
    bus_rd({1'b0, u[0], c, 1'b0});
    check(rd, code(u, c) >> 2);
    bus_rd({1'b0, u[0], c, 1'b1});
    check(rd, {code(u, c) & 10'h003, 6'h00});
  endtask : res_chk

  task automatic t_reset();
    for (int a = 0; a < 20; a++) begin
      bus_rd(5'(a));
      check(rd, a >= 18 ? 8'h7F : 8'h00);
    end
    bus_rd(5'h1F);
    check(rd, 8'h00);
  endtask : t_reset

  task automatic t_single();
    bus_wr(CSR0_OFF, 8'h61);
    // the write's idle cycle already ran converting
    n = 1;
    while (conv[0] === 1'b1 && n < 600) begin
      n++;
      @(negedge ref_clk_i);
    end
    check(n, 266);
    check(irq, 2'b01);
    // flag kept: no read of the flag before this write
    bus_wr(CSR0_OFF, 8'h41);
    bus_rd(CSR0_OFF);
    check(rd, 8'hC1);
    bus_wr(CSR0_OFF, 8'hC1);
    bus_rd(CSR0_OFF);
    check(rd, 8'hC1);
    bus_wr(CSR0_OFF, 8'h41);
    bus_rd(CSR0_OFF);
    check(rd, 8'h41);
    check(irq, 2'b00);
    bus_wr(CSR0_OFF, 8'hC1);
    bus_rd(CSR0_OFF);
    check(rd, 8'h41);
    res_chk(2'd0, 2'd1);
  endtask : t_single

  task automatic t_scan();
    // set while idle; speed zero at 40 MHz
    bus_wr(CSR1_OFF, 8'h32);
    repeat (770) @(negedge ref_clk_i);
    bus_rd(CSR1_OFF);
    check(rd, 8'h32);
    repeat (15) @(negedge ref_clk_i);
    bus_rd(CSR1_OFF);
    check(rd, 8'hB2);
    check(irq[1], 1'b0);
    check(sel[1], 2'h0);
    bus_wr(CSR1_OFF, 8'h12);
    check(conv[1], 1'b0);
    for (int c = 0; c < 3; c++)
      res_chk(2'd1, 2'(c));
    // lower byte alone gives the stale latch
    bus_rd(5'h03);
    check(rd, {code(2'd1, 2'd2) & 10'h003, 6'h00});
  endtask : t_scan

  task automatic pulse_timer();
    timer = 1'b1;
    @(negedge ref_clk_i);
    timer = 1'b0;
    @(negedge ref_clk_i);
  endtask : pulse_timer

  task automatic stop_both();
    bus_wr(CSR0_OFF, 8'h00);
    bus_wr(CSR1_OFF, 8'h00);
  endtask : stop_both

  task automatic t_trig();
    pulse_timer();
    check(conv, 2'b00);
    bus_wr(TCR1_OFF, 8'hFF);
    bus_rd(TCR1_OFF);
    check(rd, 8'hFF);
    pulse_timer();
    check(conv, 2'b11);
    stop_both();
    bus_wr(TCR1_OFF, 8'h7F);
    bus_wr(TCR0_OFF, 8'hFF);
    pin_n = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check(conv, 2'b11);
    pin_n = 1'b1;
    stop_both();
  endtask : t_trig

  task automatic t_xfer();
    // speed bit stays zero above 20 MHz
    bus_wr(CSR0_OFF, 8'h60);
    repeat (270) @(negedge ref_clk_i);
    check(irq, 2'b01);
    xfer = 2'b01;
    @(negedge ref_clk_i);
    xfer = 2'b00;
    @(negedge ref_clk_i);
    check(irq, 2'b00);
    // standby wipes everything a manual reset would keep
    standby = 1'b1;
    @(negedge ref_clk_i);
    standby = 1'b0;
    bus_rd(5'h00);
    check(rd, 8'h00);
    bus_rd(CSR0_OFF);
    check(rd, 8'h00);
    bus_rd(TCR0_OFF);
    check(rd, 8'h7F);
  endtask : t_xfer

  initial begin
    repeat (12) @(negedge ref_clk_i);
    reset_i = 1'b0;
    t_reset();
    t_single();
    t_scan();
    t_trig();
    t_xfer();
    conclude();
  end

  // whole run is about 1500 cycles
  initial begin
    #(25 * 6000);
    num_errors++;
    conclude();
  end
endmodule : testbench

// ===== adcif_top.sv
// register, sequencing and trigger logic for two four-input converter units
// How it works
// - result upper byte holds bits 9..2, lower byte bits 1..0, rest zero.
// - unit0 inputs 0..3 and unit1 inputs 4..7 map to results A..D.
// - results clear on power-on reset and standby only.
// - control/status clears on power-on reset and standby only.
// - end flag sets at single conversion end or after whole scan group.
// - end flag clears by writing zero after reading it one; one ignored.
// - transfer controller register access also clears the end flag.
// - interrupt enable bit 6 gates the completion interrupt.
// - run bit starts; single clears it when done; scan runs on.
// - writing zero to run halts; run reads one while active.
// - external trigger can also set the run bit.
// - bit 4 picks single or scan; software changes it while idle.
// - speed bit picks first conversion of 266 or 134 states.
// - control/status bit 2 reads zero; software writes zero.
// - channel field picks one input, or first one to four in scan.
// - trigger control resets to 0x7F on power-on reset and standby.
// - trigger enable bit starts on pin final edge or timer trigger.
// - both units share pin and timer trigger; enables are ORed.
// - trigger control bits 6..0 read one; software writes one.
// - upper byte read copies lower byte to latch; lower read returns it.
// - upper byte must be read first; word reads split upper first.
// - completion interrupt when end flag is one and enable is one.
// - scan starts at first input, walks in order, wraps while running.
// - later conversions take 256 or 128 states by speed bit.
`timescale 1ns/1ps
module adcif_top
  import adcif_pkg::*;
(
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          standby_i,
  input  wire adcif_bus_req_t                bus_req_i,
  output logic       [7:0]                   bus_rdata_o,
  input  wire logic                          external_trigger_pin_n_i,
  input  wire logic                          timer_trigger_i,
  input  wire logic  [UNITS-1:0]             xfer_access_i,
  input  wire logic  [UNITS-1:0][RES_W-1:0]  core_data_i,
  output logic       [UNITS-1:0][1:0]        channel_sel_o,
  output logic       [UNITS-1:0]             converting_o,
  output logic       [UNITS-1:0]             completion_interrupt_o
);

  adcif_state_t     s;
  adcif_state_t     next_s;
  logic [UNITS-1:0] done;
  logic [UNITS-1:0] flag_set;
  logic [UNITS-1:0] flag_clr;
  logic [UNITS-1:0] start_req;
  logic             trig;

  function automatic adcif_state_t reset_state();
    adcif_state_t r;
    r = '0;
    for (int i = 0; i < UNITS; i++) begin
      r.u[i].trigger_enable_bit = 1'b0;
    end
    // pin idles high: no false edge right after reset
    r.pin_prev = 1'b1;
    return r;
  endfunction : reset_state

  // new run uses the freshly written mode, channel and speed
  function automatic adcif_unit_t start_unit(adcif_unit_t x);
    adcif_unit_t y;
    y = x;
    y.run = 1'b1;
    y.cur = x.scan ? 2'b00 : x.channel_field;
    y.cnt = x.speed_bit ? FIRST_FAST_CYC : FIRST_SLOW_CYC;
    return y;
  endfunction : start_unit

  always_comb begin
    logic        is_csr;
    logic        is_tcr;
    logic        w;
    logic [1:0]  ch;
    logic [7:0]  wd;
    adcif_unit_t x;
    is_csr = 1'b0;
    is_tcr = 1'b0;
    w = 1'b0;
    ch = 2'b00;
    wd = bus_req_i.wdata;
    x = '0;
    next_s = s;
    next_s.pin_prev = external_trigger_pin_n_i;
    // final edge of the low-active pin
    // one pin, one timer, enables ORed
    trig = ((~external_trigger_pin_n_i & s.pin_prev) | timer_trigger_i)
           & (s.u[0].trigger_enable_bit | s.u[1].trigger_enable_bit);
    for (int i = 0; i < UNITS; i++) begin
      x = s.u[i];
      w = 1'(i);
      is_csr = bus_req_i.addr == (w ? CSR1_OFF : CSR0_OFF);
      is_tcr = bus_req_i.addr == (w ? TCR1_OFF : TCR0_OFF);
      done[i] = x.run && x.cnt == CNT_ONE;
      flag_set[i] = 1'b0;
      flag_clr[i] = xfer_access_i[i];
      start_req[i] = 1'b0;
      if (done[i]) begin
        // result lands in the converted channel's slot
        next_s.u[i].result[x.cur] = core_data_i[i];
        next_s.u[i].cnt = x.speed_bit ? NEXT_FAST_CYC : NEXT_SLOW_CYC;
        if (!x.scan) begin
          next_s.u[i].run = 1'b0;
          flag_set[i] = 1'b1;
        end else if (x.cur == x.channel_field) begin
          // group done, wrap to first input
          flag_set[i] = 1'b1;
          next_s.u[i].cur = 2'b00;
        end else begin
          next_s.u[i].cur = x.cur + 2'b01;
        end
      end else if (x.run && x.cnt != CNT_ZERO) begin
        next_s.u[i].cnt = x.cnt - CNT_ONE;
      end
      // clear only after the flag was seen set
      if (bus_req_i.rd && is_csr && x.end_flag) begin
        next_s.u[i].flag_seen = 1'b1;
      end
      if (bus_req_i.wr && is_csr) begin
        next_s.u[i].flag_seen = 1'b0;
        if (!wd[FLAG_BIT] && x.flag_seen) begin
          flag_clr[i] = 1'b1;
        end
        next_s.u[i].interrupt_enable_bit = wd[IE_BIT];
        // mode and channel taken as written
        next_s.u[i].scan = wd[SCAN_BIT];
        next_s.u[i].speed_bit = wd[SPEED_BIT];
        next_s.u[i].channel_field = wd[1:0];
        if (!wd[RUN_BIT]) begin
          next_s.u[i].run = 1'b0;
          next_s.u[i].cnt = CNT_ZERO;
        end else if (!x.run) begin
          start_req[i] = 1'b1;
        end
      end
      if (trig && !next_s.u[i].run) begin
        start_req[i] = 1'b1;
      end
      if (start_req[i]) begin
        next_s.u[i] = start_unit(next_s.u[i]);
      end
      if (bus_req_i.wr && is_tcr) begin
        next_s.u[i].trigger_enable_bit = wd[TRIGGER_ENABLE_BIT_BIT];
      end
      // event in the clearing cycle is kept
      next_s.u[i].end_flag = (x.end_flag & ~flag_clr[i]) | flag_set[i];
    end
    next_s.rdata = RDATA_NONE;
    if (bus_req_i.rd) begin
      if (bus_req_i.addr <= RESULT_LAST) begin
        w = bus_req_i.addr[UNIT_SEL_BIT];
        ch = bus_req_i.addr[2:1];
        if (!bus_req_i.addr[0]) begin
          // upper byte direct, lower byte into latch
          next_s.rdata = s.u[w].result[ch][RES_W-1:2];
          next_s.temp = {s.u[w].result[ch][1:0], LOW_PAD};
        end else begin
          // lower byte always from the latch
          next_s.rdata = s.temp;
        end
      end else if (bus_req_i.addr == CSR0_OFF
                   || bus_req_i.addr == CSR1_OFF) begin
        x = s.u[bus_req_i.addr[0]];
        next_s.rdata = {x.end_flag, x.interrupt_enable_bit, x.run, x.scan,
                        x.speed_bit, 1'b0, x.channel_field};
      end else if (bus_req_i.addr == TCR0_OFF
                   || bus_req_i.addr == TCR1_OFF) begin
        next_s.rdata = {s.u[bus_req_i.addr[0]].trigger_enable_bit,
                        TCR_RSVD_ONES};
      end
    end
    if (standby_i) begin
      next_s = reset_state();
      next_s.pin_prev = external_trigger_pin_n_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  assign bus_rdata_o = s.rdata;
  always_comb begin
    for (int i = 0; i < UNITS; i++) begin
      channel_sel_o[i] = s.u[i].cur;
      converting_o[i] = s.u[i].run;
      completion_interrupt_o[i] = s.u[i].end_flag
                                  & s.u[i].interrupt_enable_bit;
    end
  end

  // result word the bus addresses, for the read-back checks
  logic [RES_W-1:0] addr_result;
  assign addr_result =
    s.u[bus_req_i.addr[UNIT_SEL_BIT]].result[bus_req_i.addr[2:1]];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  property p_single_stop;
    done[0] && !s.u[0].scan && !standby_i && !bus_req_i.wr && !trig
      |=> !converting_o[0] && s.u[0].end_flag;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single conversion did not stop with flag set");

  property p_flag_one_ignored;
    bus_req_i.wr && bus_req_i.addr == CSR0_OFF && bus_req_i.wdata[FLAG_BIT]
      && !s.u[0].end_flag && !done[0]
      |=> !s.u[0].end_flag;
  endproperty
  a_flag_one_ignored: assert property (p_flag_one_ignored)
    else $error("writing one set the end flag");

  property p_flag_clear;
    bus_req_i.rd && bus_req_i.addr == CSR0_OFF && s.u[0].end_flag
      && !bus_req_i.wr && !standby_i
      ##1 !bus_req_i.wr && !standby_i
      ##1 bus_req_i.wr && bus_req_i.addr == CSR0_OFF
      && !bus_req_i.wdata[FLAG_BIT] && !done[0] && !standby_i
      |=> !s.u[0].end_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("read-then-write-zero did not clear end flag");

  property p_irq;
    done[0] && !s.u[0].scan && s.u[0].interrupt_enable_bit
      && !bus_req_i.wr && !standby_i
      |=> completion_interrupt_o[0];
  endproperty
  a_irq: assert property (p_irq)
    else $error("completion interrupt missing");

  property p_csr_rsvd;
    bus_req_i.rd && bus_req_i.addr == CSR1_OFF && !standby_i
      |=> bus_rdata_o[2] == 1'b0
          && bus_rdata_o[RUN_BIT] == $past(s.u[1].run);
  endproperty
  a_csr_rsvd: assert property (p_csr_rsvd)
    else $error("control/status read back wrong");

  property p_tcr_ones;
    bus_req_i.rd && bus_req_i.addr == TCR0_OFF && !standby_i
      |=> bus_rdata_o[6:0] == TCR_RSVD_ONES;
  endproperty
  a_tcr_ones: assert property (p_tcr_ones)
    else $error("trigger control reserved bits not one");

  property p_latch;
    bus_req_i.rd && bus_req_i.addr <= RESULT_LAST && !bus_req_i.addr[0]
      && !standby_i ##1 !bus_req_i.rd && !standby_i
      ##1 bus_req_i.rd && bus_req_i.addr <= RESULT_LAST
      && bus_req_i.addr[0] && !standby_i
      |=> bus_rdata_o == {$past(addr_result[1:0], 3), LOW_PAD};
  endproperty
  a_latch: assert property (p_latch)
    else $error("lower byte not taken from latch");

  property p_standby;
    standby_i |=> s.u[1].result == '0 && !converting_o[1]
                  && !s.u[1].trigger_enable_bit && !s.u[1].end_flag;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby did not clear unit state");

  property p_first_time;
    $rose(converting_o[0]) && !s.u[0].speed_bit
      |-> ##[1:266] (done[0] || !converting_o[0]);
  endproperty
  a_first_time: assert property (p_first_time)
    else $error("first conversion took too long");

  property p_trigger;
    trig && !converting_o[1] && !standby_i |=> converting_o[1];
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger did not start unit1");

  property p_store0;
    done[0] && !standby_i
      |=> s.u[0].result[$past(s.u[0].cur)] == $past(core_data_i[0]);
  endproperty
  a_store0: assert property (p_store0)
    else $error("unit0 result not stored in its channel slot");

  property p_scan_end;
    done[1] && s.u[1].scan && s.u[1].cur == s.u[1].channel_field
      && !bus_req_i.wr && !standby_i
      |=> s.u[1].end_flag && s.u[1].cur == 2'b00 && converting_o[1];
  endproperty
  a_scan_end: assert property (p_scan_end)
    else $error("scan group end did not flag and wrap");

  property p_scan_step;
    done[1] && s.u[1].scan && s.u[1].cur != s.u[1].channel_field
      && !bus_req_i.wr && !standby_i
      |=> s.u[1].cur == $past(s.u[1].cur) + 2'b01 && converting_o[1];
  endproperty
  a_scan_step: assert property (p_scan_step)
    else $error("scan did not step to the next input");

  property p_next_len;
    done[1] && s.u[1].scan && !s.u[1].speed_bit && !bus_req_i.wr
      && !standby_i
      |=> s.u[1].cnt == NEXT_SLOW_CYC;
  endproperty
  a_next_len: assert property (p_next_len)
    else $error("later conversion length wrong");

  property p_halt;
    bus_req_i.wr && bus_req_i.addr == CSR0_OFF
      && !bus_req_i.wdata[RUN_BIT] && !trig && !standby_i
      |=> !converting_o[0];
  endproperty
  a_halt: assert property (p_halt)
    else $error("writing zero to run did not halt unit0");

  property p_start;
    bus_req_i.wr && bus_req_i.addr == CSR0_OFF && bus_req_i.wdata[RUN_BIT]
      && !bus_req_i.wdata[SCAN_BIT] && !converting_o[0] && !standby_i
      |=> converting_o[0] && channel_sel_o[0] == $past(bus_req_i.wdata[1:0]);
  endproperty
  a_start: assert property (p_start)
    else $error("writing one to run did not start unit0");

  property p_trig_off;
    timer_trigger_i && !s.u[0].trigger_enable_bit
      && !s.u[1].trigger_enable_bit && !bus_req_i.wr && !standby_i
      && !converting_o[0] |=> !converting_o[0];
  endproperty
  a_trig_off: assert property (p_trig_off)
    else $error("disabled trigger started a conversion");

  property p_pin_start;
    !external_trigger_pin_n_i && s.pin_prev && s.u[0].trigger_enable_bit
      && !converting_o[1] && !standby_i
      |=> converting_o[1];
  endproperty
  a_pin_start: assert property (p_pin_start)
    else $error("unit0 trigger enable did not start unit1");

  property p_xfer_clear;
    xfer_access_i[0] && !done[0] && !standby_i |=> !s.u[0].end_flag;
  endproperty
  a_xfer_clear: assert property (p_xfer_clear)
    else $error("transfer access did not clear end flag");

  property p_standby_regs;
    standby_i |=> !s.u[0].interrupt_enable_bit && !s.u[0].scan
                  && !s.u[0].speed_bit && s.u[0].channel_field == 2'b00
                  && !s.u[0].trigger_enable_bit;
  endproperty
  a_standby_regs: assert property (p_standby_regs)
    else $error("standby did not clear unit0 control");

  property p_upper;
    bus_req_i.rd && bus_req_i.addr <= RESULT_LAST && !bus_req_i.addr[0]
      && !standby_i
      |=> bus_rdata_o == $past(addr_result[RES_W-1:2]);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper result byte read back wrong");

endmodule : adcif_top
